// ### verilog/isr_top.sv
// Interrupt source router: system exceptions and fan-out of device interrupts
`timescale 1ns/1ps
`default_nettype none
`include "isr_cfg.svh"
module isr_top #(
	parameter int NUM_IRQ = `ISR_NUM_IRQ,
	parameter int NUM_EXT_PIN = `ISR_NUM_EXT_PIN,
	parameter int NUM_SHARED = `ISR_NUM_SHARED
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Reset sources
	input wire logic system_reset_pin_n_i,
	input wire logic power_on_reset_pin_n_i,
	input wire logic warm_reset_pin_n_i,
	input wire logic watchdog_error_i,
	input wire logic watchdog_resp_nmi_i,
	input wire logic cpu_sysreset_req_i,
	input wire logic sysreset_reg_i,
	// Non-maskable and fault sources
	input wire logic nonmaskable_request_pin_n_i,
	input wire logic [2:0] fault_pending_i,
	input wire logic [2:0] fault_handler_en_i,
	input wire logic hard_fault_req_i,
	// Device interrupt sources
	input wire logic [NUM_IRQ-1:0] periph_irq_i,
	input wire logic [3:0] timer32_array_irq_i,
	input wire logic [15:0] timer16_array_irq_i,
	input wire logic [3:0] gen_dma_done_irq_i,
	input wire logic rt_port_dma_done_irq_i,
	input wire logic watchdog_alarm_irq_i,
	input wire logic watchdog_75pct_i,
	input wire logic os_accelerator_irq_i,
	input wire logic field_link_nonmaskable_irq_i,
	input wire logic field_link_general_irq_i,
	input wire logic phy0_led2_irq_i,
	input wire logic phy1_led2_irq_i,
	input wire logic [NUM_EXT_PIN-1:0] external_pin_irq_i,
	input wire logic field_link_watchdog_pin_n_i,
	input wire logic [NUM_SHARED-1:0] pin_or_timer_source_select_i,
	// Outputs
	output isr_pkg::isr_route_t route_o,
	output isr_pkg::isr_sys_t sys_exc_o,
	output isr_pkg::isr_sys_exc_t top_exc_o,
	output logic signed [2:0] top_prio_o
);
	localparam int NSYNC = NUM_EXT_PIN + 5;

	// Exception number to destination class; one table serves every line
	function automatic isr_pkg::isr_dest_t dest_class(input logic [7:0] exc);
		isr_pkg::isr_dest_t d;
		d = isr_pkg::ISR_DEST_NONE;
		if (exc == `ISR_EXC_OS_ACCEL)
			d = isr_pkg::ISR_DEST_CPU_ONLY;
		else if ((exc <= 8'h1F) || (exc >= 8'h26 && exc <= 8'h32)
			|| (exc >= 8'h3F && exc <= 8'h5B) || exc == 8'h6F || exc == 8'h70
			|| (exc >= `ISR_EXC_FL_NMI && exc <= `ISR_EXC_FL_GEN)
			|| exc == 8'h8A || exc == 8'h8B)
			d = isr_pkg::ISR_DEST_ALL;
		else if ((exc >= 8'h5D && exc <= 8'h65) || exc == 8'h68 || exc == 8'h69
			|| exc == 8'h6E || exc == 8'h89 || (exc >= 8'h8C && exc <= 8'h8E))
			d = isr_pkg::ISR_DEST_CPU_OS;
		return d;
	endfunction

	function automatic int idx(input logic [7:0] exc);
		return int'(exc - `ISR_FIRST_EXC);
	endfunction

	// Pin levels come from outside the clock domain
	logic [NSYNC-1:0] pin_async;
	logic [NSYNC-1:0] pin_sync;
	logic [NUM_EXT_PIN-1:0] ext_sync;
	logic nmi_pin_n_sync;
	logic fl_wdt_n_sync;
	logic [2:0] rst_pin_n_sync;
	assign pin_async = {external_pin_irq_i, nonmaskable_request_pin_n_i,
		field_link_watchdog_pin_n_i, system_reset_pin_n_i, power_on_reset_pin_n_i,
		warm_reset_pin_n_i};
	isr_sync #(
		.W(NSYNC),
		.RST_VAL({{NUM_EXT_PIN{1'b0}}, 5'h1F})
	) u_sync (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.async_i(pin_async),
		.sync_o(pin_sync)
	);
	assign ext_sync = pin_sync[NSYNC-1:5];
	assign nmi_pin_n_sync = pin_sync[4];
	assign fl_wdt_n_sync = pin_sync[3];
	assign rst_pin_n_sync = pin_sync[2:0];

	// Assemble the 128 device lines
	logic [NUM_IRQ-1:0] src;
	always_comb
	begin
		src = periph_irq_i;
		src[idx(`ISR_EXC_TIMER32_0) +: 4] = timer32_array_irq_i;
		src[idx(`ISR_EXC_GEN_DMA_0) +: 4] = gen_dma_done_irq_i;
		src[idx(`ISR_EXC_RT_DMA)] = rt_port_dma_done_irq_i;
		src[idx(`ISR_EXC_TIMER16_0) +: 5] = timer16_array_irq_i[4:0];
		src[idx(`ISR_EXT_PIN_EXC) +: NUM_EXT_PIN] = ext_sync;
		for (int k = 0; k < NUM_SHARED; k++)
		begin
			if (pin_or_timer_source_select_i[k])
				src[idx(`ISR_EXT_PIN_EXC) + `ISR_SHARED_PIN_FIRST + k] =
					timer16_array_irq_i[`ISR_SHARED_TIMER_FIRST + k];
		end
		src[idx(`ISR_EXC_OS_ACCEL)] = os_accelerator_irq_i;
		src[idx(`ISR_EXC_WDT_ALARM)] = watchdog_alarm_irq_i | watchdog_75pct_i;
		src[idx(`ISR_EXC_FL_NMI)] = field_link_nonmaskable_irq_i;
		src[idx(`ISR_EXC_FL_WDT)] = ~fl_wdt_n_sync;
		src[idx(`ISR_EXC_FL_GEN)] = field_link_general_irq_i;
		src[idx(`ISR_EXC_PHY0_LED2)] = phy0_led2_irq_i;
		src[idx(`ISR_EXC_PHY1_LED2)] = phy1_led2_irq_i;
	end

	// Fan-out; the masks fold to constants, so gating costs no gates, only wires or zeros
	isr_pkg::isr_route_t route_next;
	always_comb
	begin
		route_next = '0;
		for (int i = 0; i < NUM_IRQ; i++)
		begin
			case (dest_class(8'(i) + `ISR_FIRST_EXC))
				isr_pkg::ISR_DEST_ALL:
				begin
					route_next.cpu[i] = src[i];
					route_next.os[i] = src[i];
					route_next.gen_dma[i] = src[i];
					route_next.rt_dma[i] = src[i];
					route_next.timer[i] = src[i];
				end
				isr_pkg::ISR_DEST_CPU_OS:
				begin
					route_next.cpu[i] = src[i];
					route_next.os[i] = src[i];
				end
				isr_pkg::ISR_DEST_CPU_ONLY:
					route_next.cpu[i] = src[i];
				default:
					route_next.cpu[i] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			route_o <= '0;
		else
			route_o <= route_next;
	end

	// System exceptions
	isr_pkg::isr_sys_t sys_next;
	always_comb
	begin
		sys_next.reset = (~&rst_pin_n_sync) | (watchdog_error_i & ~watchdog_resp_nmi_i)
			| cpu_sysreset_req_i | sysreset_reg_i;
		sys_next.nmi = ~nmi_pin_n_sync | (watchdog_error_i & watchdog_resp_nmi_i);
		sys_next.hard_fault = hard_fault_req_i
			| (|(fault_pending_i & ~fault_handler_en_i));
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			sys_exc_o <= '0;
		else
			sys_exc_o <= sys_next;
	end

	// Fixed priority: reset over NMI over hard fault
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			top_exc_o <= isr_pkg::ISR_EXC_NONE;
			top_prio_o <= `ISR_PRIO_NONE;
		end
		else if (sys_next.reset)
		begin
			top_exc_o <= isr_pkg::ISR_EXC_RESET;
			top_prio_o <= `ISR_PRIO_RESET;
		end
		else if (sys_next.nmi)
		begin
			top_exc_o <= isr_pkg::ISR_EXC_NMI;
			top_prio_o <= `ISR_PRIO_NMI;
		end
		else if (sys_next.hard_fault)
		begin
			top_exc_o <= isr_pkg::ISR_EXC_HARD_FAULT;
			top_prio_o <= `ISR_PRIO_HARD_FAULT;
		end
		else
		begin
			top_exc_o <= isr_pkg::ISR_EXC_NONE;
			top_prio_o <= `ISR_PRIO_NONE;
		end
	end

	property p_reserved_idle;
		@(posedge clock_i) disable iff (!nrst_i)
		!(route_o.cpu[16] | route_o.os[40] | route_o.timer[127] | route_o.gen_dma[90]);
	endproperty
	a_reserved_idle: assert property (p_reserved_idle) else $error("reserved line active");

	property p_os_accel_cpu_only;
		@(posedge clock_i) disable iff (!nrst_i)
		$past(os_accelerator_irq_i) |-> route_o.cpu[76] && !route_o.os[76] && !route_o.timer[76];
	endproperty
	a_os_accel_cpu_only: assert property (p_os_accel_cpu_only) else $error("line 92 misrouted");

	property p_alarm_75;
		@(posedge clock_i) disable iff (!nrst_i)
		watchdog_75pct_i |=> route_o.cpu[80] && route_o.os[80] && !route_o.gen_dma[80]
			&& !route_o.rt_dma[80];
	endproperty
	a_alarm_75: assert property (p_alarm_75) else $error("alarm line misrouted");

	property p_fl_wdt_inv;
		@(posedge clock_i) disable iff (!nrst_i)
		$fell(fl_wdt_n_sync) |=> route_o.cpu[108] && route_o.timer[108];
	endproperty
	a_fl_wdt_inv: assert property (p_fl_wdt_inv) else $error("line 124 not inverse of pin");

	property p_shared_timer;
		@(posedge clock_i) disable iff (!nrst_i)
		pin_or_timer_source_select_i[0] && timer16_array_irq_i[5] |=> route_o.rt_dma[58];
	endproperty
	a_shared_timer: assert property (p_shared_timer) else $error("line 74 not timer 5");

	property p_rt_dma_done;
		@(posedge clock_i) disable iff (!nrst_i)
		rt_port_dma_done_irq_i |=> route_o.cpu[26] && route_o.gen_dma[26] && route_o.timer[26];
	endproperty
	a_rt_dma_done: assert property (p_rt_dma_done) else $error("line 42 missing");

	property p_led2;
		@(posedge clock_i) disable iff (!nrst_i)
		phy1_led2_irq_i |=> route_o.os[125] && !route_o.timer[125] && !route_o.gen_dma[125];
	endproperty
	a_led2: assert property (p_led2) else $error("LED2 line misrouted");

	property p_reset_prio;
		@(posedge clock_i) disable iff (!nrst_i)
		sysreset_reg_i |=> sys_exc_o.reset && top_prio_o == `ISR_PRIO_RESET;
	endproperty
	a_reset_prio: assert property (p_reset_prio) else $error("reset not top priority");

	property p_nmi_wdt;
		@(posedge clock_i) disable iff (!nrst_i)
		watchdog_error_i && watchdog_resp_nmi_i |=> sys_exc_o.nmi && !sys_exc_o.reset;
	endproperty
	a_nmi_wdt: assert property (p_nmi_wdt) else $error("watchdog NMI not raised");

	property p_hard_fault;
		@(posedge clock_i) disable iff (!nrst_i)
		fault_pending_i[1] && !fault_handler_en_i[1] |=> sys_exc_o.hard_fault;
	endproperty
	a_hard_fault: assert property (p_hard_fault) else $error("hard fault not raised");
endmodule
`default_nettype wire

// ### inc/isr_cfg.svh
// Constants of the interrupt source router
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH
`define ISR_FIRST_EXC 8'h10
`define ISR_LAST_EXC 8'h8F
`define ISR_NUM_IRQ 128
`define ISR_NUM_EXT_PIN 29
`define ISR_NUM_SHARED 11
`define ISR_EXT_PIN_EXC 8'h3F
`define ISR_SHARED_PIN_FIRST 11
`define ISR_SHARED_TIMER_FIRST 5
`define ISR_EXC_TIMER32_0 8'h10
`define ISR_EXC_GEN_DMA_0 8'h26
`define ISR_EXC_RT_DMA 8'h2A
`define ISR_EXC_TIMER16_0 8'h2B
`define ISR_EXC_OS_ACCEL 8'h5C
`define ISR_EXC_WDT_ALARM 8'h60
`define ISR_EXC_FL_NMI 8'h7B
`define ISR_EXC_FL_WDT 8'h7C
`define ISR_EXC_FL_GEN 8'h7D
`define ISR_EXC_PHY0_LED2 8'h8C
`define ISR_EXC_PHY1_LED2 8'h8D
`define ISR_PRIO_RESET 3'sh5
`define ISR_PRIO_NMI 3'sh6
`define ISR_PRIO_HARD_FAULT 3'sh7
`define ISR_PRIO_NONE 3'sh0
`define ISR_SYNC_STAGES 2
`endif

// ### inc/isr_pkg.sv
// Types of the interrupt source router
package isr_pkg;
	typedef enum logic [1:0] {
		ISR_DEST_NONE = 2'b00,
		ISR_DEST_CPU_ONLY = 2'b01,
		ISR_DEST_CPU_OS = 2'b10,
		ISR_DEST_ALL = 2'b11
	} isr_dest_t;
	typedef enum logic [1:0] {
		ISR_EXC_NONE = 2'b00,
		ISR_EXC_RESET = 2'b01,
		ISR_EXC_NMI = 2'b10,
		ISR_EXC_HARD_FAULT = 2'b11
	} isr_sys_exc_t;
	typedef struct packed {
		logic [127:0] cpu;
		logic [127:0] os;
		logic [127:0] gen_dma;
		logic [127:0] rt_dma;
		logic [127:0] timer;
	} isr_route_t;
	typedef struct packed {
		logic reset;
		logic nmi;
		logic hard_fault;
	} isr_sys_t;
endpackage

// ### verilog/isr_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module isr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Levels
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			meta_reg <= RST_VAL;
			sync_o <= RST_VAL;
		end
		else
		begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ### tb/isr_consumer_model.sv
// Consumer side model: destinations that see one exception number
`timescale 1ns/1ps
`default_nettype none
module isr_consumer_model (
	// Routed levels from the router
	input wire isr_pkg::isr_route_t route_i,
	// Exception number to look at
	input wire logic [7:0] exc_i,
	// Seen by cpu, os, gen_dma, rt_dma, timer
	output logic [4:0] dest_o
);
	logic [6:0] idx;
	// Wraps 143 onto bit 127, so no range check is needed
	assign idx = exc_i[6:0] - 7'h10;
	assign dest_o = {route_i.cpu[idx], route_i.os[idx], route_i.gen_dma[idx],
		route_i.rt_dma[idx], route_i.timer[idx]};
endmodule
`default_nettype wire

// ### tb/tb_isr_top.sv
// Self-checking bench of the interrupt source router
`timescale 1ns/1ps
`default_nettype none
module tb_isr_top;
	logic clock_i = 1'b0, nrst_i = 1'b0;
	logic [2:0] rpins_n = 3'h7;
	logic watchdog_error_i = 1'b0, watchdog_resp_nmi_i = 1'b0;
	logic cpu_sysreset_req_i = 1'b0, sysreset_reg_i = 1'b0, hard_fault_req_i = 1'b0;
	logic nonmaskable_request_pin_n_i = 1'b1, field_link_watchdog_pin_n_i = 1'b1;
	logic [2:0] fault_pending_i = 3'h0, fault_handler_en_i = 3'h0;
	logic [127:0] periph_irq_i = '0;
	logic [3:0] timer32_array_irq_i = 4'h0, gen_dma_done_irq_i = 4'h0;
	logic [15:0] timer16_array_irq_i = 16'h0000;
	logic rt_port_dma_done_irq_i = 1'b0, watchdog_alarm_irq_i = 1'b0;
	logic watchdog_75pct_i = 1'b0, os_accelerator_irq_i = 1'b0;
	logic field_link_nonmaskable_irq_i = 1'b0, field_link_general_irq_i = 1'b0;
	logic phy0_led2_irq_i = 1'b0, phy1_led2_irq_i = 1'b0;
	logic [28:0] external_pin_irq_i = '0;
	logic [10:0] pin_or_timer_source_select_i = 11'h000;
	isr_pkg::isr_route_t route_o;
	isr_pkg::isr_sys_t sys_exc_o;
	isr_pkg::isr_sys_exc_t top_exc_o;
	logic signed [2:0] top_prio_o;
	logic [7:0] exc = 8'h10;
	logic [4:0] dest;
	int err_count = 0;
	int checks = 0;

	always #12.5 clock_i = ~clock_i;

	isr_top isr_top_inst (
		.clock_i, .nrst_i,
		.system_reset_pin_n_i(rpins_n[0]), .power_on_reset_pin_n_i(rpins_n[1]),
		.warm_reset_pin_n_i(rpins_n[2]), .watchdog_error_i, .watchdog_resp_nmi_i,
		.cpu_sysreset_req_i, .sysreset_reg_i, .nonmaskable_request_pin_n_i,
		.fault_pending_i, .fault_handler_en_i, .hard_fault_req_i, .periph_irq_i,
		.timer32_array_irq_i, .timer16_array_irq_i, .gen_dma_done_irq_i,
		.rt_port_dma_done_irq_i, .watchdog_alarm_irq_i, .watchdog_75pct_i,
		.os_accelerator_irq_i, .field_link_nonmaskable_irq_i, .field_link_general_irq_i,
		.phy0_led2_irq_i, .phy1_led2_irq_i, .external_pin_irq_i,
		.field_link_watchdog_pin_n_i, .pin_or_timer_source_select_i,
		.route_o, .sys_exc_o, .top_exc_o, .top_prio_o
	);

	isr_consumer_model isr_consumer_model_inst (.route_i(route_o), .exc_i(exc), .dest_o(dest));

	task automatic results();
		$display("Checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Inputs change at the falling edge, so outputs are settled there
	task automatic wait_edges(int n);
		repeat (n) @(posedge clock_i);
		@(negedge clock_i);
	endtask

	// Tiny step lets the model settle without drifting toward a rising edge
	task automatic chk_line(logic [7:0] e, logic [4:0] exp);
		exc = e;
		#0.01;
		cmp($sformatf("route %0d", e), {3'h0, exp}, {3'h0, dest});
	endtask

	task automatic sys(logic [2:0] s, isr_pkg::isr_sys_exc_t e, logic [2:0] p);
		cmp("sys_exc_o", {5'h0, s}, {5'h0, sys_exc_o});
		cmp("top_exc_o", {6'h0, e}, {6'h0, top_exc_o});
		cmp("top_prio_o", {5'h0, p}, {5'h0, top_prio_o});
	endtask

	task automatic t_walk();
		timer32_array_irq_i = 4'h1;
		gen_dma_done_irq_i = 4'h8;
		rt_port_dma_done_irq_i = 1'b1;
		timer16_array_irq_i = 16'h0001;
		{os_accelerator_irq_i, watchdog_alarm_irq_i, phy0_led2_irq_i} = 3'h7;
		{field_link_nonmaskable_irq_i, field_link_general_irq_i} = 2'h3;
		periph_irq_i = (128'h1 << 4) | (128'h1 << 95);
		wait_edges(1);
		chk_line(8'h10, 5'h1F);
		chk_line(8'h14, 5'h1F);
		chk_line(8'h26, 5'h00);
		chk_line(8'h29, 5'h1F);
		chk_line(8'h2A, 5'h1F);
		chk_line(8'h2B, 5'h1F);
		chk_line(8'h5C, 5'h10);
		chk_line(8'h60, 5'h18);
		chk_line(8'h6F, 5'h1F);
		chk_line(8'h7B, 5'h1F);
		chk_line(8'h7D, 5'h1F);
		chk_line(8'h8C, 5'h18);
		chk_line(8'h8D, 5'h00);
		{timer32_array_irq_i, gen_dma_done_irq_i, rt_port_dma_done_irq_i} = 9'h000;
		timer16_array_irq_i = 16'h0000;
		{os_accelerator_irq_i, watchdog_alarm_irq_i, phy0_led2_irq_i} = 3'h0;
		{field_link_nonmaskable_irq_i, field_link_general_irq_i} = 2'h0;
		periph_irq_i = '0;
		{watchdog_75pct_i, phy1_led2_irq_i} = 2'h3;
		wait_edges(1);
		chk_line(8'h60, 5'h18);
		chk_line(8'h8D, 5'h18);
		chk_line(8'h2A, 5'h00);
		{watchdog_75pct_i, phy1_led2_irq_i} = 2'h0;
		$display("t_walk done");
	endtask

	task automatic t_pins();
		field_link_watchdog_pin_n_i = 1'b0;
		external_pin_irq_i = 29'h10000001;
		wait_edges(2);
		chk_line(8'h7C, 5'h00);
		wait_edges(1);
		chk_line(8'h7C, 5'h1F);
		chk_line(8'h3F, 5'h1F);
		chk_line(8'h5B, 5'h1F);
		field_link_watchdog_pin_n_i = 1'b1;
		external_pin_irq_i = '0;
		wait_edges(3);
		chk_line(8'h7C, 5'h00);
		$display("t_pins done");
	endtask

	task automatic t_select();
		timer16_array_irq_i = 16'h8020;
		pin_or_timer_source_select_i = 11'h001;
		wait_edges(1);
		chk_line(8'h4A, 5'h1F);
		chk_line(8'h54, 5'h00);
		pin_or_timer_source_select_i = 11'h400;
		wait_edges(1);
		chk_line(8'h4A, 5'h00);
		chk_line(8'h54, 5'h1F);
		timer16_array_irq_i = 16'h0000;
		external_pin_irq_i = 29'h00200000;
		pin_or_timer_source_select_i = 11'h000;
		wait_edges(3);
		chk_line(8'h54, 5'h1F);
		external_pin_irq_i = '0;
		$display("t_select done");
	endtask

	task automatic t_reserved();
		logic [4:0] want;
		periph_irq_i = '1;
		wait_edges(1);
		for (int e = 16; e < 144; e++)
		begin
			if (e inside {[32:37], [51:62], [102:103], [106:109], [113:122], [126:136], 143})
				chk_line(8'(e), 5'h00);
			else if (e > 92)
			begin
				want = (e inside {[111:112], [138:139]}) ? 5'h1F : 5'h18;
				// These lines come from dedicated inputs, so the all-ones vector is ignored
				if (e inside {96, [123:125], 140, 141})
					want = 5'h00;
				chk_line(8'(e), want);
			end
		end
		periph_irq_i = '0;
		wait_edges(1);
		$display("t_reserved done");
	endtask

	task automatic t_sys();
		cpu_sysreset_req_i = 1'b1;
		nonmaskable_request_pin_n_i = 1'b0;
		wait_edges(3);
		sys(3'h6, isr_pkg::ISR_EXC_RESET, 3'h5);
		cpu_sysreset_req_i = 1'b0;
		wait_edges(1);
		sys(3'h2, isr_pkg::ISR_EXC_NMI, 3'h6);
		nonmaskable_request_pin_n_i = 1'b1;
		{watchdog_error_i, watchdog_resp_nmi_i} = 2'h3;
		wait_edges(3);
		sys(3'h2, isr_pkg::ISR_EXC_NMI, 3'h6);
		watchdog_resp_nmi_i = 1'b0;
		wait_edges(1);
		sys(3'h4, isr_pkg::ISR_EXC_RESET, 3'h5);
		watchdog_error_i = 1'b0;
		sysreset_reg_i = 1'b1;
		wait_edges(1);
		sys(3'h4, isr_pkg::ISR_EXC_RESET, 3'h5);
		sysreset_reg_i = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			rpins_n = ~(3'h1 << i);
			wait_edges(3);
			sys(3'h4, isr_pkg::ISR_EXC_RESET, 3'h5);
		end
		rpins_n = 3'h7;
		{fault_pending_i, fault_handler_en_i} = 6'h12;
		wait_edges(3);
		sys(3'h0, isr_pkg::ISR_EXC_NONE, 3'h0);
		fault_handler_en_i = 3'h0;
		wait_edges(1);
		sys(3'h1, isr_pkg::ISR_EXC_HARD_FAULT, 3'h7);
		fault_pending_i = 3'h0;
		hard_fault_req_i = 1'b1;
		wait_edges(1);
		sys(3'h1, isr_pkg::ISR_EXC_HARD_FAULT, 3'h7);
		hard_fault_req_i = 1'b0;
		$display("t_sys done");
	endtask

	// Mid-run reset clears every output at once, then requests show again
	task automatic t_reset();
		cpu_sysreset_req_i = 1'b1;
		periph_irq_i = 128'h1 << 4;
		wait_edges(1);
		nrst_i = 1'b0;
		chk_line(8'h14, 5'h00);
		sys(3'h0, isr_pkg::ISR_EXC_NONE, 3'h0);
		wait_edges(1);
		nrst_i = 1'b1;
		wait_edges(1);
		chk_line(8'h14, 5'h1F);
		sys(3'h4, isr_pkg::ISR_EXC_RESET, 3'h5);
		cpu_sysreset_req_i = 1'b0;
		periph_irq_i = '0;
		wait_edges(1);
		$display("t_reset done");
	endtask

	initial
	begin
		#75000;
		err_count++;
		results();
	end

	initial
	begin
		repeat (10) @(posedge clock_i);
		@(negedge clock_i);
		nrst_i = 1'b1;
		wait_edges(1);
		t_walk();
		t_pins();
		t_select();
		t_reserved();
		t_sys();
		t_reset();
		results();
	end
endmodule
`default_nettype wire
